//--- logic/atb_top.sv
// Acquisition timebase: sample clock, pre/post counts, logic trigger, interpolator timing,
// sample memory and PWM level outputs. Assumes a 100 MHz clk_in and an Avalon-MM master.
//
// Added by the designer: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "atb_regs.svh"

////////////////////////////////////////////////////////////////////////////////
module atb_top #(
	parameter int MEM_DEPTH = `ATB_MEM_DEPTH,
	parameter int ADDR_W = 11,
	parameter int DAC_N = `ATB_DAC_N
) (
	// Clock, reset, enable
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	// Avalon-MM slave
	input wire logic [7:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	output logic irq_out,
	// Front end and interpolator
	input wire logic [3:0] trig_cmp_in,
	input wire logic [7:0] adc_a_in,
	input wire logic [7:0] adc_b_in,
	input wire logic interp_done_in,
	output logic interp_pulse_out,
	output logic arm_out,
	output logic acq_done_out,
	output logic sample_clk_out,
	output logic [ADDR_W-1:0] mem_addr_out,
	output logic chsel_a_out,
	output logic chsel_b_out,
	// Level outputs
	output logic [DAC_N-1:0] dac_out
);

	generate
		if (MEM_DEPTH != (1 << ADDR_W) || DAC_N < 1 || DAC_N > 16) begin : g_bad_param
			$error("atb_top: unsupported parameter values");
		end
	endgenerate

	atb_pkg::atb_state_t st;
	logic [3:0] cmp_s1, cmp_s2;
	logic done_s1, done_s2, done_s3;
	logic [7:0] adc_a_s1, adc_a_s2, adc_b_s1, adc_b_s2;
	logic [2:0] osc_acc;
	logic osc_tick, tick10;
	logic [1:0] div4_cnt;
	logic [15:0] div_cnt;
	logic div_wrap;
	logic [5:0] ctrl_reg;
	logic [15:0] div_reg, pre_reg, post_reg, trig_reg;
	logic [15:0] pre_cnt, post_cnt, meas_cnt, ttime_reg;
	logic [ADDR_W-1:0] addr_reg, taddr_reg, mptr_reg;
	logic meas_busy, arm_q, done_q;
	logic [3:0] istat_reg, imask_reg;
	logic [7:0] lvl_reg [DAC_N];
	logic [7:0] pwm_cnt;
	logic [7:0] mem_a [MEM_DEPTH];
	logic [7:0] mem_b [MEM_DEPTH];
	logic wait_reg;
	logic [31:0] rdata;

	////////////////////////////////////////////////////////////////////////////////
	// Bus decode: request seen at one edge, completed at the next
	logic req, acc, acc_wr, acc_rd, start_wr, run, sample_go, cond, trig_hit, done_rise;
	logic base_tick;
	logic [3:0] ev;
	assign req = avs_read_in | avs_write_in;
	assign acc = req & ~wait_reg;
	assign acc_wr = acc & avs_write_in;
	assign acc_rd = acc & avs_read_in;
	assign start_wr = acc_wr && avs_address_in == `ATB_OFS_CTRL && avs_writedata_in[`ATB_CTRL_START];
	assign run = st == atb_pkg::ST_PRE || st == atb_pkg::ST_ARMED || st == atb_pkg::ST_POST;
	assign sample_go = div_wrap & run;
	assign cond = trig_reg[cmp_s2];
	assign trig_hit = st == atb_pkg::ST_ARMED && cond && !start_wr;
	assign done_rise = done_s2 & ~done_s3;
	assign base_tick = ctrl_reg[`ATB_CTRL_FAST] ? osc_tick : tick10;
	assign ev = {meas_busy & done_rise, arm_out & ~arm_q, trig_hit, acq_done_out & ~done_q};
	assign mem_addr_out = addr_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers; comparators and ADC codes are asynchronous to clk_in
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			cmp_s1 <= 4'h0;
			cmp_s2 <= 4'h0;
			done_s1 <= 1'b0;
			done_s2 <= 1'b0;
			done_s3 <= 1'b0;
			adc_a_s1 <= 8'h00;
			adc_a_s2 <= 8'h00;
			adc_b_s1 <= 8'h00;
			adc_b_s2 <= 8'h00;
		end else if (ce_in) begin
			cmp_s1 <= trig_cmp_in;
			cmp_s2 <= cmp_s1;
			done_s1 <= interp_done_in;
			done_s2 <= done_s1;
			done_s3 <= done_s2;
			adc_a_s1 <= adc_a_in;
			adc_a_s2 <= adc_a_s1;
			adc_b_s1 <= adc_b_in;
			adc_b_s2 <= adc_b_s1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Oscillator ticks: 40 MHz as two of every five clk_in cycles, then divide by four
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			osc_acc <= 3'h0;
			osc_tick <= 1'b0;
			div4_cnt <= 2'h0;
			tick10 <= 1'b0;
		end else if (ce_in) begin
			if (osc_acc + `ATB_OSC_NUM >= `ATB_OSC_DEN) begin
				osc_acc <= osc_acc + `ATB_OSC_NUM - `ATB_OSC_DEN;
				osc_tick <= 1'b1;
			end else begin
				osc_acc <= osc_acc + `ATB_OSC_NUM;
				osc_tick <= 1'b0;
			end
			if (osc_tick) begin
				div4_cnt <= div4_cnt + 2'h1;
			end
			tick10 <= osc_tick && div4_cnt == `ATB_TB_DIV_LAST;
		end
	end

	// Sample clock divider; period is div_reg + 1 base ticks
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			div_cnt <= 16'h0000;
			div_wrap <= 1'b0;
		end else if (ce_in) begin
			div_wrap <= 1'b0;
			if (start_wr) begin
				div_cnt <= 16'h0000;
			end else if (base_tick) begin
				if (div_cnt >= div_reg) begin
					div_cnt <= 16'h0000;
					div_wrap <= 1'b1;
				end else begin
					div_cnt <= div_cnt + 16'h0001;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Acquisition sequencer; a start write restarts from any state
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			st <= atb_pkg::ST_IDLE;
			pre_cnt <= 16'h0000;
			post_cnt <= 16'h0000;
			arm_out <= 1'b0;
			acq_done_out <= 1'b0;
			taddr_reg <= '0;
		end else if (ce_in) begin
			if (start_wr) begin
				st <= atb_pkg::ST_PRE;
				pre_cnt <= 16'h0000;
				post_cnt <= 16'h0000;
				arm_out <= 1'b0;
				acq_done_out <= 1'b0;
			end else begin
				case (st)
					atb_pkg::ST_PRE: begin
						if (sample_go) begin
							pre_cnt <= pre_cnt + 16'h0001;
							if (pre_cnt + 16'h0001 >= pre_reg) begin
								st <= atb_pkg::ST_ARMED;
								arm_out <= 1'b1;
							end
						end
					end
					atb_pkg::ST_ARMED: begin
						if (trig_hit) begin
							arm_out <= 1'b0;
							taddr_reg <= addr_reg;
							if (post_reg == 16'h0000) begin
								st <= atb_pkg::ST_DONE;
								acq_done_out <= 1'b1;
							end else begin
								st <= atb_pkg::ST_POST;
								post_cnt <= post_reg;
							end
						end
					end
					atb_pkg::ST_POST: begin
						if (sample_go) begin
							post_cnt <= post_cnt - 16'h0001;
							if (post_cnt == 16'h0001) begin
								st <= atb_pkg::ST_DONE;
								acq_done_out <= 1'b1;
							end
						end
					end
					atb_pkg::ST_IDLE, atb_pkg::ST_DONE: begin
						st <= st;
					end
					default: begin
						st <= atb_pkg::ST_IDLE;
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Gated sample clock, address counter and channel alternation
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			addr_reg <= '0;
			sample_clk_out <= 1'b0;
			chsel_a_out <= 1'b0;
			chsel_b_out <= 1'b0;
		end else if (ce_in) begin
			sample_clk_out <= sample_go;
			if (start_wr) begin
				addr_reg <= '0;
			end else if (sample_go) begin
				addr_reg <= addr_reg + 1'b1;
			end
			if (sample_go) begin
				chsel_a_out <= ctrl_reg[`ATB_CTRL_BOTH_A] ? ~chsel_a_out : ctrl_reg[`ATB_CTRL_SEL_A];
				chsel_b_out <= ctrl_reg[`ATB_CTRL_BOTH_B] ? ~chsel_b_out : ctrl_reg[`ATB_CTRL_SEL_B];
			end
		end
	end

	// Sample memory, one 8-bit code per converter per sample; not cleared by reset
	always_ff @(posedge clk_in) begin
		if (ce_in && sample_go) begin
			mem_a[addr_reg] <= adc_a_s2;
			mem_b[addr_reg] <= adc_b_s2;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Interpolator: pulse from trigger to next sample edge, then time the stretch
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			interp_pulse_out <= 1'b0;
			meas_busy <= 1'b0;
			meas_cnt <= 16'h0000;
			ttime_reg <= 16'h0000;
		end else if (ce_in) begin
			if (trig_hit) begin
				interp_pulse_out <= 1'b1;
			end else if (interp_pulse_out && div_wrap) begin
				interp_pulse_out <= 1'b0;
				meas_busy <= 1'b1;
				meas_cnt <= 16'h0000;
			end else if (meas_busy && done_rise) begin
				meas_busy <= 1'b0;
				ttime_reg <= meas_cnt;
			end else if (meas_busy && osc_tick && meas_cnt != 16'hffff) begin
				meas_cnt <= meas_cnt + 16'h0001;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Level outputs; 8'hff holds the line high so the top level is reachable
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			pwm_cnt <= 8'h00;
			dac_out <= '0;
		end else if (ce_in) begin
			pwm_cnt <= pwm_cnt + 8'h01;
			for (int i = 0; i < DAC_N; i++) begin
				dac_out[i] <= lvl_reg[i] == 8'hff || pwm_cnt < lvl_reg[i];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register writes and interrupt status
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			ctrl_reg <= `ATB_CTRL_RST;
			div_reg <= `ATB_DIV_RST;
			pre_reg <= `ATB_PRE_RST;
			post_reg <= `ATB_POST_RST;
			trig_reg <= `ATB_TRIG_RST;
			imask_reg <= `ATB_IMASK_RST;
			mptr_reg <= '0;
			for (int i = 0; i < DAC_N; i++) begin
				lvl_reg[i] <= 8'h00;
			end
		end else if (ce_in) begin
			if (acc_wr) begin
				case (avs_address_in)
					`ATB_OFS_CTRL: ctrl_reg <= {avs_writedata_in[5:1], 1'b0};
					`ATB_OFS_DIV: div_reg <= avs_writedata_in[15:0];
					`ATB_OFS_PRE: pre_reg <= avs_writedata_in[15:0];
					`ATB_OFS_POST: post_reg <= avs_writedata_in[15:0];
					`ATB_OFS_TRIG: trig_reg <= avs_writedata_in[15:0];
					`ATB_OFS_IMASK: imask_reg <= avs_writedata_in[3:0];
					`ATB_OFS_MPTR: mptr_reg <= avs_writedata_in[ADDR_W-1:0];
					default: begin
						for (int i = 0; i < DAC_N; i++) begin
							if (avs_address_in == `ATB_OFS_DAC + 8'(4 * i)) begin
								lvl_reg[i] <= avs_writedata_in[7:0];
							end
						end
					end
				endcase
			end else if (acc_rd && avs_address_in == `ATB_OFS_MDATA) begin
				mptr_reg <= mptr_reg + 1'b1;
			end
		end
	end

	// Read clears only the bits it returned, so an event landing between capture and clear is kept
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			istat_reg <= 4'h0;
			irq_out <= 1'b0;
			arm_q <= 1'b0;
			done_q <= 1'b0;
		end else if (ce_in) begin
			arm_q <= arm_out;
			done_q <= acq_done_out;
			istat_reg <= (acc_rd && avs_address_in == `ATB_OFS_ISTAT ? istat_reg & ~avs_readdata_out[3:0] : istat_reg) | ev;
			irq_out <= |(istat_reg & imask_reg);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Bus answer: waitrequest low one cycle after the request is seen
	always_comb begin
		rdata = 32'h0000_0000;
		case (avs_address_in)
			`ATB_OFS_CTRL: rdata = {26'h0, ctrl_reg};
			`ATB_OFS_DIV: rdata = {16'h0, div_reg};
			`ATB_OFS_PRE: rdata = {16'h0, pre_reg};
			`ATB_OFS_POST: rdata = {16'h0, post_reg};
			`ATB_OFS_TRIG: rdata = {16'h0, trig_reg};
			`ATB_OFS_STAT: rdata = {27'h0, meas_busy, st == atb_pkg::ST_POST, run, arm_out, acq_done_out};
			`ATB_OFS_TTIME: rdata = {16'h0, ttime_reg};
			`ATB_OFS_TADDR: rdata = 32'(taddr_reg);
			`ATB_OFS_ISTAT: rdata = {28'h0, istat_reg};
			`ATB_OFS_IMASK: rdata = {28'h0, imask_reg};
			`ATB_OFS_MPTR: rdata = 32'(mptr_reg);
			`ATB_OFS_MDATA: rdata = {16'h0, mem_b[mptr_reg], mem_a[mptr_reg]};
			default: begin
				for (int i = 0; i < DAC_N; i++) begin
					if (avs_address_in == `ATB_OFS_DAC + 8'(4 * i)) begin
						rdata = {24'h0, lvl_reg[i]};
					end
				end
			end
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			wait_reg <= 1'b1;
			avs_readdata_out <= 32'h0000_0000;
		end else if (ce_in) begin
			wait_reg <= !(req && wait_reg);
			if (req && wait_reg && avs_read_in) begin
				avs_readdata_out <= rdata;
			end
		end
	end
	assign avs_waitrequest_out = wait_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	AST_OSC_SPACING: assert property (ce_in && osc_tick |=> !osc_tick)
		else $error("40 MHz tick on two adjacent cycles");
	AST_QUARTER_TICK: assert property ($past(ce_in) && tick10 |-> $past(osc_tick) && $past(div4_cnt) == 2'h3)
		else $error("10 MHz tick not on fourth oscillator tick");
	AST_ARM: assert property (ce_in && st == atb_pkg::ST_PRE && sample_go && !start_wr
		&& pre_cnt + 16'h0001 >= pre_reg |=> arm_out && st == atb_pkg::ST_ARMED)
		else $error("arm missing after pretrigger count");
	AST_TRIG_LOAD: assert property (ce_in && trig_hit && post_reg != 16'h0000
		|=> st == atb_pkg::ST_POST && post_cnt == $past(post_reg) && !arm_out)
		else $error("posttrigger count not loaded on trigger");
	AST_TRIG_COND: assert property (ce_in && st == atb_pkg::ST_ARMED && !start_wr && !cond |=> st == atb_pkg::ST_ARMED)
		else $error("trigger fired without its condition");
	AST_DONE: assert property (ce_in && st == atb_pkg::ST_POST && sample_go && !start_wr
		&& post_cnt == 16'h0001 |=> acq_done_out && st == atb_pkg::ST_DONE ##1 !sample_clk_out)
		else $error("countdown end did not stop sampling");
	AST_STOPPED: assert property ($past(st) == atb_pkg::ST_DONE && st == atb_pkg::ST_DONE |-> !sample_clk_out)
		else $error("sample clock running after completion");
	AST_ADDR_STEP: assert property (ce_in && sample_go && !start_wr |=> addr_reg == $past(addr_reg) + 1'b1)
		else $error("address counter did not step once per sample");
	AST_PULSE: assert property (ce_in && trig_hit |=> interp_pulse_out)
		else $error("interpolator pulse not started on trigger");
	AST_MEAS: assert property (ce_in && meas_busy && done_rise && !interp_pulse_out && !trig_hit
		|=> ttime_reg == $past(meas_cnt) && !meas_busy)
		else $error("stretch count not stored");
	AST_DAC_FULL: assert property (ce_in && lvl_reg[0] == 8'hff |=> dac_out[0])
		else $error("full level output not held high");
	AST_ALTERNATE: assert property (ce_in && sample_go && ctrl_reg[`ATB_CTRL_BOTH_A]
		|=> chsel_a_out != $past(chsel_a_out))
		else $error("pair select did not alternate");
	AST_RESTART: assert property (ce_in && start_wr |=> st == atb_pkg::ST_PRE && !acq_done_out && pre_cnt == 16'h0000)
		else $error("restart did not clear sequencer");

endmodule

//--- logic/atb_regs.svh
// Register map, field positions, reset values and timing constants of the acquisition timebase.
// Included by atb_top; holds definitions only.
`ifndef ATB_REGS_SVH
`define ATB_REGS_SVH

// Timing: system clock, timebase oscillator and the 40 MHz tick as a fraction of clk_in
`define ATB_CLK_HZ 100000000
`define ATB_OSC_HZ 40000000
`define ATB_FRAC_HZ 20000000
`define ATB_OSC_NUM 3'(`ATB_OSC_HZ / `ATB_FRAC_HZ)
`define ATB_OSC_DEN 3'(`ATB_CLK_HZ / `ATB_FRAC_HZ)
`define ATB_TB_DIV_LAST 2'h3
`define ATB_INTERP_FACTOR 250
`define ATB_MEM_DEPTH 2048
`define ATB_DAC_N 16

// Byte offsets
`define ATB_OFS_CTRL 8'h00
`define ATB_OFS_DIV 8'h04
`define ATB_OFS_PRE 8'h08
`define ATB_OFS_POST 8'h0c
`define ATB_OFS_TRIG 8'h10
`define ATB_OFS_STAT 8'h14
`define ATB_OFS_TTIME 8'h18
`define ATB_OFS_TADDR 8'h1c
`define ATB_OFS_ISTAT 8'h20
`define ATB_OFS_IMASK 8'h24
`define ATB_OFS_MPTR 8'h28
`define ATB_OFS_MDATA 8'h2c
`define ATB_OFS_DAC 8'h40

// Control fields
`define ATB_CTRL_START 0
`define ATB_CTRL_FAST 1
`define ATB_CTRL_BOTH_A 2
`define ATB_CTRL_BOTH_B 3
`define ATB_CTRL_SEL_A 4
`define ATB_CTRL_SEL_B 5

// Interrupt status bits
`define ATB_IRQ_DONE 0
`define ATB_IRQ_TRIG 1
`define ATB_IRQ_ARM 2
`define ATB_IRQ_MEAS 3

// Reset values
`define ATB_CTRL_RST 6'h00
`define ATB_DIV_RST 16'h0000
`define ATB_PRE_RST 16'h0400
`define ATB_POST_RST 16'h0400
`define ATB_TRIG_RST 16'hfffe
`define ATB_IMASK_RST 4'h0

`endif

//--- logic/atb_pkg.sv
// Types shared by the acquisition timebase.
// No dependencies.
package atb_pkg;
	typedef enum logic [2:0] {ST_IDLE, ST_PRE, ST_ARMED, ST_POST, ST_DONE} atb_state_t;
endpackage

//--- verification/atb_interp_model.sv
// Behavioural interpolator at the far side of the timing pulse.
// Assumes a registered pulse level from the timebase on clk_in.
`timescale 1ns/1ps
module atb_interp_model #(
	parameter int FACTOR = 250
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Timing pulse in, stretch complete out
	input wire logic pulse_in,
	output logic done_out
);
	int w_cnt;
	int left;
	logic pulse_d;
	always @(posedge clk_in) begin
		pulse_d <= pulse_in;
		if (rst_in) begin
			w_cnt <= 0;
			left <= 0;
			done_out <= 1'b0;
		end else if (pulse_in && !pulse_d) begin
			// A new pulse withdraws the previous completion
			w_cnt <= 1;
			done_out <= 1'b0;
		end else if (pulse_in) begin
			w_cnt <= w_cnt + 1;
		end else if (pulse_d) begin
			left <= w_cnt * FACTOR;
		end else if (left > 0) begin
			left <= left - 1;
			if (left == 1) begin
				done_out <= 1'b1;
			end
		end
	end
endmodule

//--- verification/tb_acquisition_trigger_timebase.sv
// Self-checking bench for the acquisition timebase over its Avalon-MM port.
// Assumes atb_top and the interpolator model; one 100 MHz clock.
`timescale 1ns/1ps
`include "atb_regs.svh"
module tb_acquisition_trigger_timebase;
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic ce = 1'b1;
	logic [7:0] adr = 8'h00;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wd = 32'h0;
	logic [3:0] cmp = 4'h0;
	logic [7:0] adc_a = 8'h5a;
	logic [7:0] adc_b = 8'hc3;
	logic [31:0] rdat;
	logic [31:0] q;
	logic wreq, irq, pulse, idone, arm, adone, smp, csa, csb;
	logic [10:0] maddr;
	logic [15:0] dac;
	logic prev_a = 1'b0;
	int n_mismatch = 0;
	int compares = 0;
	int cyc = 0, n_smp = 0, last = 0, gap = 0, w_cnt = 0, alt_err = 0, n, w0;
	logic [7:0] ra [8] = '{`ATB_OFS_CTRL, `ATB_OFS_DIV, `ATB_OFS_PRE, `ATB_OFS_POST,
		`ATB_OFS_TRIG, `ATB_OFS_IMASK, `ATB_OFS_DAC, 8'h30};
	logic [31:0] rv [8] = '{32'h0, 32'h0, 32'h400, 32'h400, 32'hfffe, 32'h0, 32'h0, 32'h0};
	int dl [3] = '{256, 0, 64};
	int pdv [3] = '{3, 1, 1};
	logic pf [3] = '{1'b1, 1'b0, 1'b1};
	int pg [3] = '{10, 20, 5};
	always #5 clk_in = ~clk_in;
	atb_top dut (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce), .avs_address_in(adr), .avs_read_in(rd),
		.avs_write_in(wr), .avs_writedata_in(wd), .avs_readdata_out(rdat), .avs_waitrequest_out(wreq),
		.irq_out(irq), .trig_cmp_in(cmp), .adc_a_in(adc_a), .adc_b_in(adc_b), .interp_done_in(idone),
		.interp_pulse_out(pulse), .arm_out(arm), .acq_done_out(adone), .sample_clk_out(smp),
		.mem_addr_out(maddr), .chsel_a_out(csa), .chsel_b_out(csb), .dac_out(dac));
	atb_interp_model partner (.clk_in(clk_in), .rst_in(rst_in), .pulse_in(pulse), .done_out(idone));
	////////////////////////////////////////
	// Sample, gap and pulse-width monitors; also the run ceiling
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (pulse === 1'b1) w_cnt <= w_cnt + 1;
		if (smp === 1'b1) begin
			n_smp <= n_smp + 1;
			gap <= cyc - last;
			last <= cyc;
			if (csa === prev_a) alt_err <= alt_err + 1;
			prev_a <= csa;
		end
		if (cyc == 60000) begin
			n_mismatch = n_mismatch + 1;
			conclude();
		end
	end
	////////////////////////////////////////
	task conclude();
		if (n_mismatch == 0 && compares > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task rng(input string what, input int lo, input int hi, input logic [31:0] got);
		compares++;
		if ((got >= lo && got <= hi) !== 1'b1) begin
			n_mismatch++;
			$display("wrong value %s expected %0d..%0d seen %0d", what, lo, hi, got);
		end
	endtask
	// One Avalon access; read data lands in q at the edge waitrequest is seen low
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clk_in);
		adr <= a;
		wr <= w;
		rd <= !w;
		wd <= d;
		k = 0;
		do begin
			@(posedge clk_in);
			k++;
		end while (wreq !== 1'b0 && k < 50);
		chk("bus answer", 1'b0, wreq);
		q = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task wt(input int sel, input logic v);
		int k;
		k = 0;
		// Look only after an edge, so a level cleared by the last bus access is not seen stale
		do begin
			@(posedge clk_in);
			k++;
		end while ((sel == 0 ? arm : sel == 1 ? adone : idone) !== v && k < 40000);
		chk("level reached", v, sel == 0 ? arm : sel == 1 ? adone : idone);
	endtask
	// One acquisition: mode is {both_a, fast}; c0 is the comparator pattern before arming
	task acq(input logic [1:0] mode, input int div, input int pre, input int post, input logic [3:0] c0,
		input logic msk);
		int s0, s1, a0;
		bus(1'b1, `ATB_OFS_DIV, div);
		bus(1'b1, `ATB_OFS_PRE, pre);
		bus(1'b1, `ATB_OFS_POST, post);
		bus(1'b1, `ATB_OFS_IMASK, {31'h0, msk});
		bus(1'b1, `ATB_OFS_TRIG, 32'h0008);
		cmp <= c0;
		bus(1'b1, `ATB_OFS_CTRL, {28'h0, mode[1], mode, 1'b1});
		// A sample launched on the start edge itself belongs to the old run
		repeat (2) @(posedge clk_in);
		s0 = n_smp;
		wt(0, 1'b1);
		rng("pre samples", pre - 1, pre + 1, n_smp - s0);
		a0 = alt_err;
		repeat (30) @(posedge clk_in);
		chk("arm held", c0 != 4'h3, arm);
		cmp <= 4'h3;
		wt(0, 1'b0);
		s1 = n_smp;
		wt(1, 1'b1);
		rng("post samples", post > 0 ? post - 1 : 0, post + 1, n_smp - s1);
		repeat (4) @(posedge clk_in);
		s1 = n_smp;
		chk("address", 32'(11'(n_smp - s0)), {21'h0, maddr});
		if (mode[1]) chk("alternation", a0, alt_err);
		chk("select b", {31'h0, csa}, {31'h0, csb});
		bus(1'b0, `ATB_OFS_TADDR, 32'h0);
		rng("trigger address", maddr - post - 1, maddr - post, q);
		repeat (50) @(posedge clk_in);
		chk("stopped", s1, n_smp);
		chk("irq", msk, irq);
		bus(1'b0, `ATB_OFS_STAT, 32'h0);
		chk("status", 32'h1, {29'h0, q[2:0]});
		bus(1'b0, `ATB_OFS_ISTAT, 32'h0);
		chk("events", 32'h7, {29'h0, q[2:0]});
		repeat (3) @(posedge clk_in);
		chk("irq cleared", 1'b0, irq);
		chk("done held", 1'b1, adone);
	endtask
	////////////////////////////////////////
	initial begin
		repeat (8) @(posedge clk_in);
		rst_in <= 1'b0;
		bus(1'b1, 8'h30, 32'hffffffff);
		for (int i = 0; i < 8; i++) begin
			bus(1'b0, ra[i], 32'h0);
			chk("reset value", rv[i], q);
		end
		chk("irq idle", 1'b0, irq);
		bus(1'b1, `ATB_OFS_DAC, 32'hff);
		bus(1'b1, `ATB_OFS_DAC + 8'h08, 32'h40);
		bus(1'b0, `ATB_OFS_DAC + 8'h08, 32'h0);
		chk("level", 32'h40, q);
		repeat (260) @(posedge clk_in);
		for (int i = 0; i < 3; i++) begin
			n = 0;
			repeat (256) begin
				@(posedge clk_in);
				n += (dac[i] === 1'b1);
			end
			chk("duty", dl[i], n);
		end
		// Long pretrigger keeps the clock running while the gap is measured
		for (int i = 0; i < 3; i++) begin
			bus(1'b1, `ATB_OFS_DIV, pdv[i]);
			bus(1'b1, `ATB_OFS_PRE, 32'hffff);
			bus(1'b1, `ATB_OFS_CTRL, {30'h0, pf[i], 1'b1});
			repeat (100) @(posedge clk_in);
			chk("period", pg[i], gap);
		end
		// Clock enable low must freeze the running address counter
		ce <= 1'b0;
		@(posedge clk_in);
		n = maddr;
		repeat (20) @(posedge clk_in);
		chk("frozen address", n, maddr);
		ce <= 1'b1;
		w0 = w_cnt;
		acq(2'b11, 3, 4, 5, 4'h5, 1'b1);
		n = w_cnt - w0;
		rng("pulse width", 1, 11, n);
		wt(2, 1'b1);
		repeat (10) @(posedge clk_in);
		bus(1'b0, `ATB_OFS_TTIME, 32'h0);
		rng("timing", 100 * n - 2, 100 * n + 3, q);
		bus(1'b0, `ATB_OFS_ISTAT, 32'h0);
		chk("measure event", 1'b1, q[3]);
		bus(1'b1, `ATB_OFS_MPTR, 32'h0);
		bus(1'b0, `ATB_OFS_MDATA, 32'h0);
		chk("sample", 32'h0000c35a, q);
		bus(1'b0, `ATB_OFS_MPTR, 32'h0);
		chk("pointer", 32'h1, q);
		acq(2'b01, 0, 2100, 0, 4'h3, 1'b0);
		conclude();
	end
endmodule
